// File: mtc_pkg.sv
// Constants and register map of the transmit configuration and tally block
// Summary of operation
// - Transmit config bit 7 or media control bit 7 high selects full duplex.
// - With the internal PHY in use both duplex bits are ignored.
// - Transmit config bit 6 clear pads frames shorter than 60 bytes.
// - Transmit config bit 5 set retransmits frames after a late collision.
// - Loop-back field bits 2:1: 00 normal, 01 MAC, 10 PHY, 11 reserved.
// - Transmit config bit 0 clear appends CRC; set inhibits it.
// - Alignment error tally counts address-passed misaligned frames; read clears.
// - CRC error tally counts address-passed bad-CRC frames; read clears.
// - Data config bit 0 selects byte or word data-port transfers.
// - Write-only mask holds seven interrupt enables, all disabled after reset.
// - Frames lost tally counts frames dropped for lack of buffer space.
// - In monitor mode the lost tally counts every address-passed frame.
// - Destination address is compared byte by byte with the station address.
// - Station byte 0 bit 0 holds DA0; byte 5 bit 7 holds DA47.
// - DA0, the first address bit, is the physical/multicast bit.
// - Monitor mode checks address and CRC but stores nothing in buffer.
package mtc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_SA0       = 6'h01;
	localparam logic [5:0] IDX_SA1       = 6'h02;
	localparam logic [5:0] IDX_SA5       = 6'h06;
	localparam logic [5:0] IDX_RX_CFG    = 6'h0C;
	localparam logic [5:0] IDX_TX_CFG    = 6'h0D;
	localparam logic [5:0] IDX_ALIGN     = 6'h0D;
	localparam logic [5:0] IDX_DP_CFG    = 6'h0E;
	localparam logic [5:0] IDX_CRC       = 6'h0E;
	localparam logic [5:0] IDX_MASK      = 6'h0F;
	localparam logic [5:0] IDX_LOST      = 6'h0F;
	localparam logic [5:0] IDX_MEDIA     = 6'h10;
	localparam logic [5:0] IDX_RX_CFG_RB = 6'h1C;
	localparam logic [5:0] IDX_TX_CFG_RB = 6'h1D;
	localparam logic [5:0] IDX_DP_CFG_RB = 6'h1E;
	localparam logic [5:0] IDX_MASK_RB   = 6'h1F;

	// Field positions
	localparam int TX_FDX_BIT   = 7;
	localparam int TX_PAD_BIT   = 6;
	localparam int TX_RETRY_BIT = 5;
	localparam int TX_LB_HI     = 2;
	localparam int TX_LB_LO     = 1;
	localparam int TX_CRC_BIT   = 0;
	localparam int DP_WORD_BIT  = 0;
	localparam int RX_MON_BIT   = 5;
	localparam int MC_FDX_BIT   = 7;
	localparam int MC_IPHY_BIT  = 0;
	localparam int SA_BYTES     = 6;

	// Writable bits of each register
	localparam logic [7:0] TX_CFG_MASK = 8'hE7;
	localparam logic [7:0] DP_CFG_MASK = 8'h01;
	localparam logic [7:0] IE_MASK     = 8'h7F;
	localparam logic [7:0] RX_CFG_MASK = 8'h3F;
	localparam logic [7:0] MC_MASK     = 8'h81;

	// Values after reset
	localparam logic [7:0] TX_CFG_RST = 8'h00;
	localparam logic [7:0] DP_CFG_RST = 8'h00;
	localparam logic [7:0] IE_RST     = 8'h00;
	localparam logic [7:0] RX_CFG_RST = 8'h00;
	localparam logic [7:0] MC_RST     = 8'h00;
	localparam logic [7:0] SA_RST     = 8'h00;
	localparam logic [7:0] TALLY_RST  = 8'h00;

	// Loop-back codes
	typedef enum logic [1:0] {
		MTC_LB_NORMAL = 2'h0,
		MTC_LB_MAC    = 2'h1,
		MTC_LB_PHY    = 2'h2,
		MTC_LB_RSVD   = 2'h3
	} mtc_lb_t;

	// AHB transfer type and response
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'b0;

endpackage : mtc_pkg

// File: mtc_regs.sv
// Register bank, tallies, address compare and interrupt gate
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
module mtc_regs (
	input  wire logic                clock,
	input  wire logic                rstn,
	// AHB-Lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	// Receive events, one-cycle pulses from the receiver
	input  wire logic                rx_frame_done,
	input  wire logic                rx_addr_pass,
	input  wire logic                rx_align_err,
	input  wire logic                rx_crc_err,
	input  wire logic                rx_no_buffer,
	// Destination address bytes, DA0 in bit 0 of the first byte
	input  wire logic                da_start,
	input  wire logic                da_valid,
	input  wire logic [7:0]          da_byte,
	// Duplex reported by the internal PHY
	input  wire logic                phy_full_duplex,
	// Pending events, bit order as the mask register
	input  wire logic [6:0]          event_pending,
	// Configuration, address compare and interrupt outputs
	output logic                     full_duplex_sel,
	output logic                     pad_enable,
	output logic                     late_coll_retry,
	output mtc_pkg::mtc_lb_t         loopback_sel,
	output logic                     crc_append,
	output logic                     word_xfer_sel,
	output logic                     listen_only_mode,
	output logic                     rx_store_en,
	output logic                     addr_match,
	output logic                     addr_done,
	output logic                     da_multicast,
	output logic                     irq
);
	import mtc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [7:0]             tx_cfg;
		logic [7:0]             dp_cfg;
		logic [7:0]             ie;
		logic [7:0]             rx_cfg;
		logic [7:0]             media;
		logic [SA_BYTES-1:0][7:0] sa;
		logic [7:0]             t_align;
		logic [7:0]             t_crc;
		logic [7:0]             t_lost;
		logic                   wr_pend;
		logic [5:0]             wr_idx;
		logic [31:0]            rdata;
		logic [2:0]             da_cnt;
		logic                   da_ok;
		logic                   match;
		logic                   done;
		logic                   mcast;
		logic                   fdx;
		mtc_lb_t                lb;
		logic                   irq;
		logic                   pad_en;
		logic                   crc_app;
		logic                   store_en;
		logic                   ready;
		logic                   resp;
	} mtc_state_t;

	mtc_state_t q;
	mtc_state_t d;

	// Word index of an aligned address inside the block, else unmapped
	function automatic logic [6:0] mtc_decode(input logic [31:0] a);
		mtc_decode = {(a[31:8] == 24'h0 && a[1:0] == 2'h0), a[7:2]};
	endfunction : mtc_decode

	logic       rd_acc;
	logic       wr_acc;
	logic [6:0] acc_dec;
	logic       inc_align;
	logic       inc_crc;
	logic       inc_lost;
	logic       mon;

	// Address phase accept and event qualification
	assign acc_dec   = mtc_decode(haddr);
	assign rd_acc    = hsel & hready & (htrans == HTRANS_NONSEQ) & ~hwrite;
	assign wr_acc    = hsel & hready & (htrans == HTRANS_NONSEQ) & hwrite;
	assign mon       = q.rx_cfg[RX_MON_BIT];
	assign inc_align = rx_frame_done & rx_addr_pass & rx_align_err;
	assign inc_crc   = rx_frame_done & rx_addr_pass & rx_crc_err;
	// Monitor mode counts recognised frames instead of drops
	assign inc_lost  = mon ? (rx_frame_done & rx_addr_pass)
		: rx_no_buffer;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d = q;
		d.wr_pend = wr_acc & acc_dec[6];
		d.wr_idx  = acc_dec[5:0];

		// Tallies count up and wrap
		d.t_align = q.t_align + {7'h00, inc_align};
		d.t_crc   = q.t_crc + {7'h00, inc_crc};
		d.t_lost  = q.t_lost + {7'h00, inc_lost};

		// Data phase write with the previous address
		if (q.wr_pend) begin
			unique case (q.wr_idx)
				IDX_TX_CFG: d.tx_cfg = hwdata[7:0] & TX_CFG_MASK;
				IDX_DP_CFG: d.dp_cfg = hwdata[7:0] & DP_CFG_MASK;
				IDX_MASK:   d.ie = hwdata[7:0] & IE_MASK;
				IDX_RX_CFG: d.rx_cfg = hwdata[7:0] & RX_CFG_MASK;
				IDX_MEDIA:  d.media = hwdata[7:0] & MC_MASK;
				default: begin
					if (q.wr_idx >= IDX_SA0 && q.wr_idx <= IDX_SA5) begin
						d.sa[3'(q.wr_idx - IDX_SA0)] = hwdata[7:0];
					end
				end
			endcase
		end

		// Read data from updated values so write-then-read sees it
		d.rdata = 32'h0000_0000;
		if (rd_acc && acc_dec[6]) begin
			unique case (acc_dec[5:0])
				IDX_ALIGN: begin
					d.rdata = {24'h0, q.t_align};
					d.t_align = {7'h00, inc_align};
				end
				IDX_CRC: begin
					d.rdata = {24'h0, q.t_crc};
					d.t_crc = {7'h00, inc_crc};
				end
				IDX_LOST:      d.rdata = {24'h0, q.t_lost};
				IDX_RX_CFG_RB: d.rdata = {24'h0, d.rx_cfg};
				IDX_TX_CFG_RB: d.rdata = {24'h0, d.tx_cfg};
				IDX_DP_CFG_RB: d.rdata = {24'h0, d.dp_cfg};
				IDX_MASK_RB:   d.rdata = {24'h0, d.ie};
				IDX_MEDIA:     d.rdata = {24'h0, d.media};
				default: begin
					if (acc_dec[5:0] >= IDX_SA0 && acc_dec[5:0] <= IDX_SA5) begin
						d.rdata = {24'h0, d.sa[3'(acc_dec[5:0] - IDX_SA0)]};
					end
				end
			endcase
		end

		// Byte-wise destination address compare
		if (da_start) begin
			d.da_cnt = 3'h0;
			d.da_ok  = 1'b1;
			d.done   = 1'b0;
			d.match  = 1'b0;
		end else if (da_valid && !q.done) begin
			d.da_ok  = q.da_ok & (da_byte == q.sa[q.da_cnt]);
			d.da_cnt = q.da_cnt + 3'h1;
			if (q.da_cnt == 3'h0) begin
				d.mcast = da_byte[0];
			end
			if (q.da_cnt == 3'(SA_BYTES - 1)) begin
				d.done  = 1'b1;
				d.match = d.da_ok;
			end
		end

		// Duplex: internal PHY overrides both control bits
		d.fdx = q.media[MC_IPHY_BIT] ? phy_full_duplex
			: (q.tx_cfg[TX_FDX_BIT] | q.media[MC_FDX_BIT]);

		// Reserved loop-back code behaves as normal operation
		unique case (q.tx_cfg[TX_LB_HI:TX_LB_LO])
			2'h1:    d.lb = MTC_LB_MAC;
			2'h2:    d.lb = MTC_LB_PHY;
			default: d.lb = MTC_LB_NORMAL;
		endcase

		d.irq = |(event_pending & q.ie[6:0]);

		// Output flops follow the next config value, so they never lag it
		d.pad_en   = ~d.tx_cfg[TX_PAD_BIT];
		d.crc_app  = ~d.tx_cfg[TX_CRC_BIT];
		d.store_en = ~d.rx_cfg[RX_MON_BIT];
		d.ready    = 1'b1;
		d.resp     = HRESP_OKAY;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			q         <= '0;
			q.tx_cfg  <= TX_CFG_RST;
			q.dp_cfg  <= DP_CFG_RST;
			q.ie      <= IE_RST;
			q.rx_cfg  <= RX_CFG_RST;
			q.media   <= MC_RST;
			q.sa      <= {SA_BYTES{SA_RST}};
			q.t_align <= TALLY_RST;
			q.t_crc   <= TALLY_RST;
			q.t_lost  <= TALLY_RST;
			q.lb      <= MTC_LB_NORMAL;
			q.pad_en   <= ~TX_CFG_RST[TX_PAD_BIT];
			q.crc_app  <= ~TX_CFG_RST[TX_CRC_BIT];
			q.store_en <= ~RX_CFG_RST[RX_MON_BIT];
			q.ready    <= 1'b1;
			q.resp     <= HRESP_OKAY;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Bus answers in the data phase with no wait states
	assign hreadyout        = q.ready;
	assign hresp            = q.resp;
	assign hrdata           = q.rdata;
	assign full_duplex_sel  = q.fdx;
	assign pad_enable       = q.pad_en;
	assign late_coll_retry  = q.tx_cfg[TX_RETRY_BIT];
	assign loopback_sel     = q.lb;
	assign crc_append       = q.crc_app;
	assign word_xfer_sel    = q.dp_cfg[DP_WORD_BIT];
	assign listen_only_mode = mon;
	assign rx_store_en      = q.store_en;
	assign addr_match       = q.match;
	assign addr_done        = q.done;
	assign da_multicast     = q.mcast;
	assign irq              = q.irq;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	a_duplex_or: assert property (@(posedge clock) disable iff (!rstn)
		(!q.media[MC_IPHY_BIT] && (q.tx_cfg[TX_FDX_BIT] || q.media[MC_FDX_BIT]))
		|=> full_duplex_sel)
		else $error("duplex bit set but half duplex selected");

	a_duplex_phy: assert property (@(posedge clock) disable iff (!rstn)
		q.media[MC_IPHY_BIT] |=> (full_duplex_sel == $past(phy_full_duplex)))
		else $error("internal PHY duplex not followed");

	a_pad_ctrl: assert property (@(posedge clock) disable iff (!rstn)
		pad_enable != q.tx_cfg[TX_PAD_BIT])
		else $error("pad enable disagrees with config");

	a_retry_ctrl: assert property (@(posedge clock) disable iff (!rstn)
		(q.wr_pend && q.wr_idx == IDX_TX_CFG)
		|=> late_coll_retry == $past(hwdata[TX_RETRY_BIT]))
		else $error("late collision retry not written");

	a_loop_mode: assert property (@(posedge clock) disable iff (!rstn)
		(q.tx_cfg[TX_LB_HI:TX_LB_LO] == 2'h2) |=> loopback_sel == MTC_LB_PHY)
		else $error("PHY loop-back not selected");

	a_crc_ctrl: assert property (@(posedge clock) disable iff (!rstn)
		(q.wr_pend && q.wr_idx == IDX_TX_CFG && hwdata[TX_CRC_BIT]) |=> !crc_append)
		else $error("CRC still appended after inhibit");

	a_align_clear: assert property (@(posedge clock) disable iff (!rstn)
		(rd_acc && acc_dec == {1'b1, IDX_ALIGN})
		|=> (hrdata[7:0] == $past(q.t_align)) && (q.t_align <= 8'h01))
		else $error("alignment tally not returned and cleared");

	a_align_count: assert property (@(posedge clock) disable iff (!rstn)
		(inc_align && !rd_acc) |=> q.t_align == $past(q.t_align) + 8'h01)
		else $error("alignment tally missed an event");

	a_crc_clear: assert property (@(posedge clock) disable iff (!rstn)
		(rd_acc && acc_dec == {1'b1, IDX_CRC} && !inc_crc) |=> q.t_crc == 8'h00)
		else $error("CRC tally not cleared by read");

	a_word_sel: assert property (@(posedge clock) disable iff (!rstn)
		(q.wr_pend && q.wr_idx == IDX_DP_CFG)
		|=> word_xfer_sel == $past(hwdata[DP_WORD_BIT]))
		else $error("word transfer select not written");

	a_mask_reset: assert property (@(posedge clock) disable iff (!rstn)
		(!q.wr_pend || q.wr_idx != IDX_MASK) |=> $stable(q.ie) && !q.ie[7])
		else $error("mask changed without a write");

	a_lost_count: assert property (@(posedge clock) disable iff (!rstn)
		(!mon && rx_no_buffer) |=> q.t_lost == $past(q.t_lost) + 8'h01)
		else $error("frames lost tally missed a drop");

	a_lost_monitor: assert property (@(posedge clock) disable iff (!rstn)
		(mon && rx_no_buffer && !rx_frame_done) |=> $stable(q.t_lost))
		else $error("monitor mode counted a buffer drop");

	a_addr_match: assert property (@(posedge clock) disable iff (!rstn)
		(da_valid && !da_start && !q.done && q.da_cnt == 3'h5 && q.da_ok
		&& da_byte == q.sa[5]) |=> addr_match && addr_done)
		else $error("matching address not flagged");

	a_addr_miss: assert property (@(posedge clock) disable iff (!rstn)
		(da_valid && !q.done && q.da_cnt == 3'h0 && da_byte != q.sa[0]
		&& !da_start) |=> !q.da_ok)
		else $error("first address byte mismatch not seen");

	a_mcast_bit: assert property (@(posedge clock) disable iff (!rstn)
		(da_valid && !da_start && !q.done && q.da_cnt == 3'h0)
		|=> da_multicast == $past(da_byte[0]))
		else $error("multicast bit not taken from DA0");

	a_mon_store: assert property (@(posedge clock) disable iff (!rstn)
		rx_store_en == !listen_only_mode)
		else $error("monitor mode still stores frames");

	a_irq_gate: assert property (@(posedge clock) disable iff (!rstn)
		(event_pending & q.ie[6:0]) == 7'h00 |=> !irq)
		else $error("interrupt without enabled event");

	a_irq_raise: assert property (@(posedge clock) disable iff (!rstn)
		(event_pending & q.ie[6:0]) != 7'h00 |=> irq)
		else $error("enabled event without interrupt");

	a_duplex_half: assert property (@(posedge clock) disable iff (!rstn)
		(!q.media[MC_IPHY_BIT] && !q.tx_cfg[TX_FDX_BIT] && !q.media[MC_FDX_BIT])
		|=> !full_duplex_sel)
		else $error("half duplex not selected");

	a_pad_write: assert property (@(posedge clock) disable iff (!rstn)
		(q.wr_pend && q.wr_idx == IDX_TX_CFG)
		|=> pad_enable == !$past(hwdata[TX_PAD_BIT]))
		else $error("pad enable not written");

	a_loop_mac: assert property (@(posedge clock) disable iff (!rstn)
		(q.tx_cfg[TX_LB_HI:TX_LB_LO] == 2'h1) |=> loopback_sel == MTC_LB_MAC)
		else $error("MAC loop-back not selected");

	a_loop_rsvd: assert property (@(posedge clock) disable iff (!rstn)
		(q.tx_cfg[TX_LB_HI:TX_LB_LO] == 2'h3) |=> loopback_sel == MTC_LB_NORMAL)
		else $error("reserved loop-back code not normal");

	a_crc_keep: assert property (@(posedge clock) disable iff (!rstn)
		(q.wr_pend && q.wr_idx == IDX_TX_CFG && !hwdata[TX_CRC_BIT]) |=> crc_append)
		else $error("CRC not appended after clear");

	a_crc_count: assert property (@(posedge clock) disable iff (!rstn)
		(inc_crc && !rd_acc) |=> q.t_crc == $past(q.t_crc) + 8'h01)
		else $error("CRC tally missed an event");

	a_mask_write: assert property (@(posedge clock) disable iff (!rstn)
		(q.wr_pend && q.wr_idx == IDX_MASK)
		|=> q.ie == ($past(hwdata[7:0]) & IE_MASK))
		else $error("interrupt mask not written");

	a_lost_read: assert property (@(posedge clock) disable iff (!rstn)
		(rd_acc && acc_dec == {1'b1, IDX_LOST} && !inc_lost)
		|=> (hrdata[7:0] == $past(q.t_lost)) && $stable(q.t_lost))
		else $error("frames lost tally changed by read");

	a_addr_hold: assert property (@(posedge clock) disable iff (!rstn)
		(q.done && !da_start) |=> $stable(addr_match) && addr_done)
		else $error("address result lost before restart");

	a_store_write: assert property (@(posedge clock) disable iff (!rstn)
		(q.wr_pend && q.wr_idx == IDX_RX_CFG)
		|=> rx_store_en == !$past(hwdata[RX_MON_BIT]))
		else $error("store enable not written");

endmodule : mtc_regs

// File: mtc_host.sv
// Behavioural host that issues single AHB-Lite word transfers
`timescale 1ns/1ps
module mtc_host (
	input  wire logic        clock,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	import mtc_pkg::*;
	////////////////////////////////////////////////////////////////////////
	// Bus starts idle
	initial begin
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
	end
	// One whole-word transfer; ok stays low if the slave never answers
	task automatic xfer(input logic [5:0] idx, input logic wr,
		input logic [7:0] wd, output logic [31:0] rd, output logic ok);
		int n;
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h000000, idx, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= 3'h2;
		hwdata <= ~hwdata; // Released data lines do not hold
		n = 0;
		do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 64);
		if (hready !== 1'b1) n = 128; // Address phase never taken
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? {24'h000000, wd} : ~hwdata;
		do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 128);
		rd = hrdata;
		ok = (n < 128);
	endtask : xfer
endmodule : mtc_host

// File: mac_tx_cfg_tally_addr_regs_test.sv
// Self-checking bench for the transmit config, tally and address block
`timescale 1ns/1ps
module mac_tx_cfg_tally_addr_regs_test;
	import mtc_pkg::*;
	logic        clock, rstn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        rx_frame_done, rx_addr_pass, rx_align_err, rx_crc_err;
	logic        rx_no_buffer, da_start, da_valid, phy_full_duplex;
	logic [7:0]  da_byte;
	logic [6:0]  event_pending;
	logic        full_duplex_sel, pad_enable, late_coll_retry, crc_append;
	logic        word_xfer_sel, listen_only_mode, rx_store_en, irq;
	logic        addr_match, addr_done, da_multicast;
	mtc_lb_t     loopback_sel;
	int          num_errors, checks_done;
	////////////////////////////////////////////////////////////////////////
	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;
	mtc_regs mtc_regs_inst (.clock, .rstn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .rx_frame_done,
		.rx_addr_pass, .rx_align_err, .rx_crc_err, .rx_no_buffer, .da_start,
		.da_valid, .da_byte, .phy_full_duplex, .event_pending, .full_duplex_sel,
		.pad_enable, .late_coll_retry, .loopback_sel, .crc_append,
		.word_xfer_sel, .listen_only_mode, .rx_store_en, .addr_match,
		.addr_done, .da_multicast, .irq);
	mtc_host mtc_host_inst (.clock, .hready, .hrdata, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata);
	// 25 MHz clock
	always #20 clock = ~clock;
	////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [5:0] idx, input logic [7:0] v);
		logic [31:0] d;
		logic        ok;
		mtc_host_inst.xfer(idx, 1'b1, v, d, ok);
		if (ok !== 1'b1) begin num_errors++; end_sim(); end
	endtask : wr
	task automatic rdc(input logic [5:0] idx, input logic [7:0] e, string nm);
		logic [31:0] d;
		logic        ok;
		mtc_host_inst.xfer(idx, 1'b0, 8'h00, d, ok);
		if (ok !== 1'b1) begin num_errors++; end_sim(); end
		chk(nm, {24'h000000, e}, d);
		chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
	endtask : rdc
	// Let registered outputs land
	task automatic settle;
		repeat (2) @(posedge clock);
		#1;
	endtask : settle
	// One receive event; unqualified lines do not hold their value
	task automatic ev(input logic fd, ap, al, cr, nb);
		@(posedge clock);
		rx_frame_done <= fd;
		rx_addr_pass <= ap;
		rx_align_err <= al;
		rx_crc_err <= cr;
		rx_no_buffer <= nb;
		@(posedge clock);
		rx_frame_done <= 1'b0;
		rx_no_buffer <= 1'b0;
		rx_addr_pass <= ~ap;
		rx_align_err <= ~al;
		rx_crc_err <= ~cr;
	endtask : ev
	// Destination address, first byte first
	task automatic da_send(input logic [47:0] da);
		@(posedge clock) da_start <= 1'b1;
		@(posedge clock) da_start <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			da_valid <= 1'b1;
			da_byte <= da[8*i +: 8];
			@(posedge clock);
		end
		da_valid <= 1'b0;
		da_byte <= ~da_byte;
		settle();
	endtask : da_send
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_txcfg;
		logic [7:0] v;
		for (int lb = 0; lb < 4; lb++) begin
			v = 8'hE1 | 8'(lb << 1);
			wr(IDX_TX_CFG, v);
			settle();
			chk("fdx", 32'h1, 32'(full_duplex_sel));
			chk("pad", 32'h0, 32'(pad_enable));
			chk("retry", 32'h1, 32'(late_coll_retry));
			chk("crc", 32'h0, 32'(crc_append));
			chk("lb", (lb == 3) ? 0 : lb, 32'(loopback_sel));
			rdc(IDX_TX_CFG_RB, v & TX_CFG_MASK, "tx rb");
		end
		wr(IDX_TX_CFG, 8'h18);
		settle();
		chk("fdx", 32'h0, 32'(full_duplex_sel));
		chk("pad", 32'h1, 32'(pad_enable));
		chk("retry", 32'h0, 32'(late_coll_retry));
		chk("crc", 32'h1, 32'(crc_append));
		chk("lb", 32'h0, 32'(loopback_sel));
	endtask : t_txcfg
	task automatic t_duplex;
		wr(IDX_MEDIA, 8'h80);
		settle();
		chk("fdx media", 32'h1, 32'(full_duplex_sel));
		wr(IDX_TX_CFG, 8'h80);
		wr(IDX_MEDIA, 8'h81);
		settle();
		chk("fdx iphy", 32'h0, 32'(full_duplex_sel));
		@(posedge clock) phy_full_duplex <= 1'b1;
		wr(IDX_TX_CFG, 8'h00);
		wr(IDX_MEDIA, 8'h01);
		settle();
		chk("fdx iphy", 32'h1, 32'(full_duplex_sel));
		wr(IDX_MEDIA, 8'h00);
		settle();
		chk("fdx off", 32'h0, 32'(full_duplex_sel));
		wr(IDX_DP_CFG, 8'hFF);
		settle();
		chk("word", 32'h1, 32'(word_xfer_sel));
		rdc(IDX_DP_CFG_RB, 8'h01, "dp rb");
	endtask : t_duplex
	task automatic t_tally;
		ev(1, 1, 1, 0, 0);
		ev(1, 1, 1, 1, 0);
		ev(1, 1, 1, 0, 0);
		ev(1, 0, 1, 1, 0);
		ev(1, 1, 0, 1, 0);
		ev(0, 1, 1, 1, 0);
		ev(0, 0, 0, 0, 1);
		ev(0, 0, 0, 0, 1);
		rdc(IDX_ALIGN, 8'h03, "align");
		rdc(IDX_ALIGN, 8'h00, "align clr");
		rdc(IDX_CRC, 8'h02, "crc");
		rdc(IDX_CRC, 8'h00, "crc clr");
		rdc(IDX_LOST, 8'h02, "lost");
		rdc(IDX_LOST, 8'h02, "lost kept");
		wr(IDX_RX_CFG, 8'h20);
		settle();
		chk("listen", 32'h1, 32'(listen_only_mode));
		chk("store", 32'h0, 32'(rx_store_en));
		ev(1, 1, 0, 0, 0);
		ev(1, 0, 0, 0, 0);
		ev(0, 0, 0, 0, 1);
		rdc(IDX_LOST, 8'h03, "lost mon");
	endtask : t_tally
	task automatic t_irq;
		for (int i = 0; i < 7; i++) begin
			wr(IDX_MASK, 8'(1 << i));
			@(posedge clock) event_pending <= ~7'(1 << i);
			settle();
			chk("irq masked", 32'h0, 32'(irq));
			@(posedge clock) event_pending <= 7'(1 << i);
			settle();
			chk("irq on", 32'h1, 32'(irq));
			@(posedge clock) event_pending <= 7'h00;
			settle();
			chk("irq off", 32'h0, 32'(irq));
		end
		wr(IDX_MASK, 8'hFF);
		rdc(IDX_MASK_RB, 8'h7F, "mask rb");
	endtask : t_irq
	// Reset in mid-run brings every register back to its reset value
	task automatic t_reset;
		@(posedge clock) rstn <= 1'b0;
		@(posedge clock) rstn <= 1'b1;
		@(posedge clock);
		#1;
		chk("fdx rst2", 32'h0, 32'(full_duplex_sel));
		chk("word rst2", 32'h0, 32'(word_xfer_sel));
		chk("store rst2", 32'h1, 32'(rx_store_en));
		rdc(IDX_MASK_RB, 8'h00, "mask rst2");
		rdc(IDX_LOST, 8'h00, "lost rst2");
		rdc(IDX_SA0, 8'h00, "station rst2");
	endtask : t_reset
	task automatic t_addr;
		logic [47:0] sa;
		sa = 48'hA55A0FF03CC3;
		for (int i = 0; i < 6; i++) wr(IDX_SA0 + 6'(i), sa[8*i +: 8]);
		for (int i = 0; i < 6; i++)
			rdc(IDX_SA0 + 6'(i), sa[8*i +: 8], "station");
		da_send(sa);
		chk("done", 32'h1, 32'(addr_done));
		chk("match", 32'h1, 32'(addr_match));
		chk("mcast", 32'h1, 32'(da_multicast));
		da_send(sa ^ 48'h800000000000);
		chk("match hi", 32'h0, 32'(addr_match));
		da_send(sa ^ 48'h000000000001);
		chk("match lo", 32'h0, 32'(addr_match));
		chk("mcast", 32'h0, 32'(da_multicast));
		rdc(6'h3F, 8'h00, "unmapped");
	endtask : t_addr
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		{rx_frame_done, rx_addr_pass, rx_align_err, rx_crc_err} = 4'h0;
		{rx_no_buffer, da_start, da_valid, phy_full_duplex} = 4'h0;
		da_byte = 8'h00;
		event_pending = 7'h00;
		num_errors = 0;
		checks_done = 0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		#1;
		chk("pad rst", 32'h1, 32'(pad_enable));
		chk("crc rst", 32'h1, 32'(crc_append));
		chk("word rst", 32'h0, 32'(word_xfer_sel));
		chk("store rst", 32'h1, 32'(rx_store_en));
		chk("fdx rst", 32'h0, 32'(full_duplex_sel));
		rdc(IDX_MASK_RB, 8'h00, "mask rst");
		t_txcfg();
		t_duplex();
		t_tally();
		t_irq();
		t_addr();
		t_reset();
		end_sim();
	end
endmodule : mac_tx_cfg_tally_addr_regs_test
